/* File: rtl/low_power_mode_sequencer.sv */
// low-power mode sequencer: backup, wait, sleep and active running
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`default_nettype none
// What this block does
// - keyed regulator-off request enters backup
// - regulator-off request needs the correct key
// - deep sleep select then wfe enters backup
// - backup turns regulator and core supply off
// - enabled pin, monitor or alarm leaves backup
// - wait regulator start-up before running again
// - regulator disable independent, core externally supplied
// - pins held in backup, pulled-up inputs after
// - wait stops core, peripheral, memory clocks
// - wait wake-up completes under ten microseconds
// - wait-entry bit enters wait, flash per select
// - software sequence before setting wait-entry bit
// - software sequence before wfe wait entry
// - flash standby, deep power-down or idle
// - pins, calendar, timer, usb wake from wait
// - pending event blocks wfe entry
// - sleep stops only the core clock
// - wfi or wfe with event-lowpower clear sleeps
// - wfi wakes on interrupt, wfe on event
// - active clock from fast rc, crystal, pll
// - backup wake re-enables core and sram supply
// - fast start restarts rc and processor clock
module low_power_mode_sequencer #(
    parameter int REG_START_CYCLES = lp_pkg::REG_START_CYC,
    parameter int FAST_START_CYCLES = lp_pkg::FRC_START_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    lp_link_if.seq           link,
    input  wire logic [15:0] wakePins,
    input  wire logic        supplyMonitorAlarm,
    input  wire logic        calendarAlarm,
    input  wire logic        periodicTimerAlarm,
    input  wire logic        usbWake,
    output logic             regulatorOn,
    output logic             coreSupplyOn,
    output logic             sramSupplyOn,
    output logic             coreClkEn,
    output logic             periphClkEn,
    output logic             memClkEn,
    output logic [1:0]       flashMode,
    output logic [1:0]       clkSrc,
    output logic             pinHold,
    output logic             pinPullupInit
);
    import lp_pkg::*;

    if (REG_START_CYCLES < 1 || REG_START_CYCLES > 65535) begin : g_chk_reg
        $error("REG_START_CYCLES out of range");
    end
    if (FAST_START_CYCLES < 1 || FAST_START_CYCLES >= WAIT_WAKE_MAX_US * 1000 / CLK_NS) begin : g_chk_fast
        $error("FAST_START_CYCLES too large");
    end

    localparam logic [15:0] REG_LAST  = 16'(REG_START_CYCLES - 1);
    localparam logic [15:0] FAST_LAST = 16'(FAST_START_CYCLES - 1);

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'b000001,
        ST_SLEEP  = 6'b000010,
        ST_WAIT   = 6'b000100,
        ST_BACKUP = 6'b001000,
        ST_REGUP  = 6'b010000,
        ST_FAST   = 6'b100000
    } state_t;

    typedef struct packed {
        state_t      st;
        logic [15:0] cnt;
        logic        byWfe;
        logic [15:0] snap;
        logic [15:0] prev;
        logic [15:0] stab;
        logic [2:0]  mode;
        logic        mck;
        logic        rst;
        logic        regOn;
        logic        coreSup;
        logic        sramSup;
        logic        cClk;
        logic        pClk;
        logic        mClk;
        logic [1:0]  flash;
        logic [1:0]  src;
        logic        hold;
        logic        pull;
    } seq_t;

    seq_t s_r, s_nxt;

    // wait-mode fast start
    function automatic logic fastStart(input logic [15:0] p, input logic [19:0] en,
                                       input logic rtc, input logic periodic_timer, input logic usb);
        fastStart = (|(~p & en[15:0])) | (rtc & en[SRC_RTC]) | (periodic_timer & en[SRC_RTT])
                    | (usb & en[SRC_USB]);
    endfunction : fastStart

    logic [15:0] enPins;
    logic        keyOk;
    logic        backupWake;
    logic        waitWake;
    assign enPins   = wakePins & link.srcEn[15:0];
    assign keyOk    = link.regOffReq && (link.regKey == REG_OFF_KEY);
    assign waitWake = fastStart(wakePins, link.srcEn, calendarAlarm, periodicTimerAlarm, usbWake);
    assign backupWake = ((enPins != s_r.snap) && (s_r.stab >= link.debounce))
                        | (supplyMonitorAlarm & link.srcEn[SRC_SM])
                        | (calendarAlarm & link.srcEn[SRC_RTC])
                        | (periodicTimerAlarm & link.srcEn[SRC_RTT]);

    // --------
    // mode sequencing
    // --------
    always_comb begin
        s_nxt      = s_r;
        s_nxt.rst  = 1'b0;
        s_nxt.pull = 1'b0;
        s_nxt.prev = enPins;
        if (enPins != s_r.prev) begin
            s_nxt.stab = 16'h0;
        end else if (s_r.stab != 16'hFFFF) begin
            s_nxt.stab = s_r.stab + 16'h1;
        end
        case (s_r.st)
            ST_ACTIVE: begin
                s_nxt.src   = link.clkSel;
                s_nxt.pClk  = !link.periphOff;
                s_nxt.regOn = !link.regDisable;
                if (keyOk || (link.waitForEventInstr && link.deepSleepSelect && !link.eventPend)) begin
                    s_nxt.st      = ST_BACKUP;
                    s_nxt.snap    = enPins;
                    s_nxt.regOn   = 1'b0;
                    s_nxt.coreSup = 1'b0;
                    s_nxt.sramSup = 1'b0;
                    s_nxt.cClk    = 1'b0;
                    s_nxt.pClk    = 1'b0;
                    s_nxt.mClk    = 1'b0;
                    s_nxt.mck     = 1'b0;
                    s_nxt.hold    = 1'b1;
                    s_nxt.mode    = MODE_BACKUP;
                end else if (link.waitEntryBit
                             || (link.waitForEventInstr && link.lowpowerOnEvent && !link.eventPend)) begin
                    s_nxt.st    = ST_WAIT;
                    s_nxt.cClk  = 1'b0;
                    s_nxt.pClk  = 1'b0;
                    s_nxt.mClk  = 1'b0;
                    s_nxt.mck   = 1'b0;
                    s_nxt.flash = (link.flashLowpowerSelect == FLASH_ON) ? FLASH_STANDBY
                                  : link.flashLowpowerSelect;
                    s_nxt.mode  = MODE_WAIT;
                end else if (link.waitForInterruptInstr
                             || (link.waitForEventInstr && !link.eventPend)) begin
                    s_nxt.st    = ST_SLEEP;
                    s_nxt.byWfe = link.waitForEventInstr;
                    s_nxt.cClk  = 1'b0;
                    s_nxt.mode  = MODE_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (link.intPend || (s_r.byWfe && (link.eventPend || waitWake))) begin
                    s_nxt.st   = ST_ACTIVE;
                    s_nxt.cClk = 1'b1;
                    s_nxt.mode = MODE_ACTIVE;
                end
            end
            ST_WAIT: begin
                if (waitWake) begin
                    s_nxt.st   = ST_FAST;
                    s_nxt.cnt  = 16'h0;
                    s_nxt.src  = CLK_FAST_RC;
                    s_nxt.mode = MODE_WAKING;
                end
            end
            ST_FAST: begin
                s_nxt.cnt = s_r.cnt + 16'h1;
                if (s_r.cnt == FAST_LAST) begin
                    s_nxt.st    = ST_ACTIVE;
                    s_nxt.cClk  = 1'b1;
                    s_nxt.pClk  = !link.periphOff;
                    s_nxt.mClk  = 1'b1;
                    s_nxt.flash = FLASH_ON;
                    s_nxt.mck   = 1'b1;
                    s_nxt.mode  = MODE_ACTIVE;
                end
            end
            ST_BACKUP: begin
                if (backupWake) begin
                    s_nxt.st      = ST_REGUP;
                    s_nxt.cnt     = 16'h0;
                    s_nxt.regOn   = 1'b1;
                    s_nxt.coreSup = 1'b1;
                    s_nxt.sramSup = 1'b1;
                    s_nxt.mode    = MODE_WAKING;
                end
            end
            ST_REGUP: begin
                s_nxt.cnt = s_r.cnt + 16'h1;
                if (s_r.cnt == REG_LAST) begin
                    s_nxt.st    = ST_ACTIVE;
                    s_nxt.rst   = 1'b1;
                    s_nxt.hold  = 1'b0;
                    s_nxt.pull  = 1'b1;
                    s_nxt.src   = CLK_FAST_RC;
                    s_nxt.cClk  = 1'b1;
                    s_nxt.pClk  = 1'b1;
                    s_nxt.mClk  = 1'b1;
                    s_nxt.flash = FLASH_ON;
                    s_nxt.mck   = 1'b1;
                    s_nxt.mode  = MODE_ACTIVE;
                end
            end
            default: begin
                s_nxt.st = ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{st: ST_ACTIVE, mode: MODE_ACTIVE, mck: 1'b1, regOn: 1'b1, coreSup: 1'b1, sramSup: 1'b1,
                     cClk: 1'b1, pClk: 1'b1, mClk: 1'b1, flash: FLASH_ON, src: CLK_FAST_RC, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.mode             = s_r.mode;
    assign link.masterClockReady = s_r.mck;
    assign link.coreRst          = s_r.rst;
    assign regulatorOn           = s_r.regOn;
    assign coreSupplyOn          = s_r.coreSup;
    assign sramSupplyOn          = s_r.sramSup;
    assign coreClkEn             = s_r.cClk;
    assign periphClkEn           = s_r.pClk;
    assign memClkEn              = s_r.mClk;
    assign flashMode             = s_r.flash;
    assign clkSrc                = s_r.src;
    assign pinHold               = s_r.hold;
    assign pinPullupInit         = s_r.pull;
endmodule : low_power_mode_sequencer
`default_nettype wire

/* File: rtl/lp_core_ctrl.sv */
// core-side controller: AHB-Lite register slave driving the sequencer link
`default_nettype none
module lp_core_ctrl (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        irq,
    lp_link_if.ctl           link
);
    import lp_pkg::*;

    typedef struct packed {
        logic        dpWr;
        logic [7:0]  dpAddr;
        logic [31:0] rdata;
        logic        rdy;
        logic        regOffReq;
        logic [7:0]  regKey;
        logic        deep;
        logic        lpEvt;
        logic        regDis;
        logic [1:0]  flashLp;
        logic [1:0]  clkSel;
        logic        periphOff;
        logic        waitPulse;
        logic        wait_for_interrupt_instr;
        logic        wait_for_event_instr;
        logic        evt;
        logic        irqPrev;
        logic [19:0] srcEn;
        logic [15:0] debounce;
    } ctl_t;

    ctl_t s_r, s_nxt;

    // --------
    // register bus and event flag
    // --------
    always_comb begin
        s_nxt           = s_r;
        s_nxt.regOffReq = 1'b0;
        s_nxt.waitPulse = 1'b0;
        s_nxt.wait_for_interrupt_instr       = 1'b0;
        s_nxt.wait_for_event_instr       = 1'b0;
        s_nxt.dpWr      = 1'b0;
        s_nxt.rdy       = 1'b1;
        s_nxt.irqPrev   = irq;
        if (s_r.dpWr) begin
            case (s_r.dpAddr)
                OFS_CTRL: begin
                    s_nxt.regOffReq = hwdata[CTRL_REGOFF];
                    s_nxt.regKey    = hwdata[CTRL_KEY_LO +: 8];
                    s_nxt.deep      = hwdata[CTRL_DEEP];
                    s_nxt.lpEvt     = hwdata[CTRL_LPEVT];
                    s_nxt.regDis    = hwdata[CTRL_REGDIS];
                    s_nxt.flashLp   = hwdata[CTRL_FLASH_LO +: 2];
                    s_nxt.clkSel    = hwdata[CTRL_CLK_LO +: 2];
                    s_nxt.periphOff = hwdata[CTRL_PERIOFF];
                    s_nxt.waitPulse = hwdata[CTRL_WAIT];
                end
                OFS_INSTR: begin
                    s_nxt.wait_for_interrupt_instr = hwdata[INSTR_WFI];
                    s_nxt.wait_for_event_instr = hwdata[INSTR_WFE];
                end
                OFS_WAKEEN:   s_nxt.srcEn    = hwdata[19:0];
                OFS_DEBOUNCE: s_nxt.debounce = hwdata[15:0];
                default: ;
            endcase
        end
        if (hsel && htrans[1] && hready) begin
            s_nxt.dpWr   = hwrite;
            s_nxt.dpAddr = haddr[7:0];
            s_nxt.rdata  = 32'h0;
            if (!hwrite) begin
                case (haddr[7:0])
                    OFS_CTRL: s_nxt.rdata = {23'h0, s_r.periphOff, s_r.clkSel, s_r.flashLp,
                                             s_r.regDis, s_r.lpEvt, s_r.deep, 1'b0};
                    OFS_WAKEEN:   s_nxt.rdata = {12'h0, s_r.srcEn};
                    OFS_DEBOUNCE: s_nxt.rdata = {16'h0, s_r.debounce};
                    OFS_STATUS:   s_nxt.rdata = {26'h0, irq, s_r.evt, link.masterClockReady, link.mode};
                    default:      s_nxt.rdata = 32'h0;
                endcase
            end
        end
        // set wins over the wfe clear
        if (s_r.wait_for_event_instr) begin
            s_nxt.evt = 1'b0;
        end
        if (irq && !s_r.irqPrev) begin
            s_nxt.evt = 1'b1;
        end
        if (link.coreRst) begin
            s_nxt.deep      = 1'b0;
            s_nxt.lpEvt     = 1'b0;
            s_nxt.regDis    = 1'b0;
            s_nxt.flashLp   = FLASH_STANDBY;
            s_nxt.clkSel    = CLK_FAST_RC;
            s_nxt.periphOff = 1'b0;
            s_nxt.evt       = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata                     = s_r.rdata;
    assign hreadyout                  = s_r.rdy;
    assign hresp                      = 1'b0;
    assign link.regOffReq             = s_r.regOffReq;
    assign link.regKey                = s_r.regKey;
    assign link.deepSleepSelect       = s_r.deep;
    assign link.lowpowerOnEvent       = s_r.lpEvt;
    assign link.regDisable            = s_r.regDis;
    assign link.flashLowpowerSelect   = s_r.flashLp;
    assign link.clkSel                = s_r.clkSel;
    assign link.periphOff             = s_r.periphOff;
    assign link.waitEntryBit          = s_r.waitPulse;
    assign link.waitForInterruptInstr = s_r.wait_for_interrupt_instr;
    assign link.waitForEventInstr     = s_r.wait_for_event_instr;
    assign link.eventPend             = s_r.evt;
    assign link.intPend               = s_r.irqPrev;
    assign link.srcEn                 = s_r.srcEn;
    assign link.debounce              = s_r.debounce;
endmodule : lp_core_ctrl
`default_nettype wire

/* File: rtl/lp_link_if.sv */
// link between the core-side controller and the low-power sequencer
`default_nettype none
interface lp_link_if;
    logic        regOffReq;
    logic [7:0]  regKey;
    logic        deepSleepSelect;
    logic        lowpowerOnEvent;
    logic        regDisable;
    logic [1:0]  flashLowpowerSelect;
    logic [1:0]  clkSel;
    logic        periphOff;
    logic        waitEntryBit;
    logic        waitForInterruptInstr;
    logic        waitForEventInstr;
    logic        eventPend;
    logic        intPend;
    logic [19:0] srcEn;
    logic [15:0] debounce;
    logic [2:0]  mode;
    logic        masterClockReady;
    logic        coreRst;
    modport ctl (output regOffReq, regKey, deepSleepSelect, lowpowerOnEvent, regDisable,
                 flashLowpowerSelect, clkSel, periphOff, waitEntryBit, waitForInterruptInstr,
                 waitForEventInstr, eventPend, intPend, srcEn, debounce,
                 input mode, masterClockReady, coreRst);
    modport seq (input regOffReq, regKey, deepSleepSelect, lowpowerOnEvent, regDisable,
                 flashLowpowerSelect, clkSel, periphOff, waitEntryBit, waitForInterruptInstr,
                 waitForEventInstr, eventPend, intPend, srcEn, debounce,
                 output mode, masterClockReady, coreRst);
endinterface : lp_link_if
`default_nettype wire

/* File: rtl/lp_pkg.sv */
// shared constants for the low-power mode sequencer and its core-side controller
`default_nettype none
package lp_pkg;
    // --------
    // timing
    // --------
    localparam int CLK_NS           = 10;
    localparam int REG_START_US     = 300;
    localparam int REG_START_CYC    = (REG_START_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_WAKE_MAX_US = 10;
    localparam int FRC_START_NS     = 2000;
    localparam int FRC_START_CYC    = FRC_START_NS / CLK_NS;
    // --------
    // wake sources and regulator-off key
    // --------
    localparam int SRC_SM   = 16;
    localparam int SRC_RTC  = 17;
    localparam int SRC_RTT  = 18;
    localparam int SRC_USB  = 19;
    localparam logic [7:0] REG_OFF_KEY = 8'hA5;
    // --------
    // mode report, flash modes and clock source
    // --------
    localparam logic [2:0] MODE_ACTIVE = 3'h0;
    localparam logic [2:0] MODE_SLEEP  = 3'h1;
    localparam logic [2:0] MODE_WAIT   = 3'h2;
    localparam logic [2:0] MODE_BACKUP = 3'h3;
    localparam logic [2:0] MODE_WAKING = 3'h4;
    localparam logic [1:0] FLASH_STANDBY = 2'h0;
    localparam logic [1:0] FLASH_DEEPPD  = 2'h1;
    localparam logic [1:0] FLASH_IDLE    = 2'h2;
    localparam logic [1:0] FLASH_ON      = 2'h3;
    localparam logic [1:0] CLK_FAST_RC   = 2'h0;
    // --------
    // controller registers (byte addresses) and bit positions
    // --------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_INSTR    = 8'h04;
    localparam logic [7:0] OFS_WAKEEN   = 8'h08;
    localparam logic [7:0] OFS_DEBOUNCE = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam int CTRL_REGOFF   = 0;
    localparam int CTRL_DEEP     = 1;
    localparam int CTRL_LPEVT    = 2;
    localparam int CTRL_REGDIS   = 3;
    localparam int CTRL_FLASH_LO = 4;
    localparam int CTRL_CLK_LO   = 6;
    localparam int CTRL_PERIOFF  = 8;
    localparam int CTRL_WAIT     = 9;
    localparam int CTRL_KEY_LO   = 24;
    localparam int INSTR_WFI     = 0;
    localparam int INSTR_WFE     = 1;
endpackage : lp_pkg
`default_nettype wire

/* File: sim/low_power_mode_sequencer_tb.sv */
// self-checking bench: bus-driven mode entry and wake-up
`default_nettype none
module low_power_mode_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lp_pkg::*;
    localparam int REG_CYC  = 20;
    localparam int FAST_CYC = 5;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             hsel = 1'b0;
    logic             hwrite = 1'b0;
    logic [1:0]       htrans = 2'h0;
    logic [31:0]      haddr = 32'h0;
    logic [31:0]      hwdata = 32'h0;
    logic             irq = 1'b0;
    logic [15:0]      wakePins = 16'hFFFF;
    logic [3:0]       alarms = 4'h0;
    logic             sawPull = 1'b0;
    logic [31:0]      rdat;
    logic [31:0]      v;
    wire logic [31:0] hrdata;
    wire logic        hready;
    wire logic        regOn, coreOn, sramOn, coreClkEn, periClkEn, memClkEn, pinHold, pullInit;
    wire logic [1:0]  flashMode, clkSrc;
    wire logic [10:0] outs;
    int               fails = 0;
    int               n_compared = 0;
    int               n;
    assign outs = {regOn, coreOn, sramOn, coreClkEn, periClkEn, memClkEn, flashMode, clkSrc, pinHold};
    lp_link_if link ();
    lp_core_ctrl i_lp_core_ctrl (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(), .irq(irq), .link(link));
    low_power_mode_sequencer #(.REG_START_CYCLES(REG_CYC), .FAST_START_CYCLES(FAST_CYC)) i_low_power_mode_sequencer (
        .clk(clk), .rst_b(rst_b), .link(link), .wakePins(wakePins), .supplyMonitorAlarm(alarms[0]),
        .calendarAlarm(alarms[1]), .periodicTimerAlarm(alarms[2]), .usbWake(alarms[3]), .regulatorOn(regOn),
        .coreSupplyOn(coreOn), .sramSupplyOn(sramOn), .coreClkEn(coreClkEn), .periphClkEn(periClkEn),
        .memClkEn(memClkEn), .flashMode(flashMode), .clkSrc(clkSrc), .pinHold(pinHold), .pinPullupInit(pullInit));
    lp_assertions #(.REG_START_CYCLES(REG_CYC), .FAST_START_CYCLES(FAST_CYC)) i_lp_assertions (.clk(clk),
        .rst_b(rst_b), .regOffReq(link.regOffReq), .regKey(link.regKey), .deepSleepSelect(link.deepSleepSelect),
        .lowpowerOnEvent(link.lowpowerOnEvent), .waitEntryBit(link.waitEntryBit),
        .waitForInterruptInstr(link.waitForInterruptInstr), .waitForEventInstr(link.waitForEventInstr),
        .eventPend(link.eventPend), .intPend(link.intPend), .mode(link.mode),
        .masterClockReady(link.masterClockReady), .coreRst(link.coreRst));
    always #5 clk = ~clk;
    always @(posedge clk) if (pullInit === 1'b1) sawPull <= 1'b1;
    // --------
    // bus and check tasks
    // --------
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask : ahb
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_mode(input logic [2:0] m);
        n = 0;
        while (link.mode !== m && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check({29'h0, link.mode}, {29'h0, m});
    endtask : wait_mode
    task automatic end_sim;
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin : watchdog
        #300000;
        fails++;
        end_sim();
    end
    // --------
    // scenarios
    // --------
    initial begin : main
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({21'h0, outs}, 32'h7F8);
        ahb(1'b0, OFS_STATUS, 32'h0);
        check(rdat, 32'h8);
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        ahb(1'b0, 8'h20, 32'h0);
        check(rdat, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h000000A0);
        ahb(1'b0, OFS_CTRL, 32'h0);
        check(rdat, 32'hA0);
        check({30'h0, clkSrc}, 32'h2);
        ahb(1'b1, OFS_CTRL, 32'h5A000001);
        repeat (5) @(posedge clk);
        check({28'h0, regOn, link.mode}, {28'h0, 1'b1, MODE_ACTIVE});
        ahb(1'b1, OFS_CTRL, 32'h8);
        repeat (3) @(posedge clk);
        check({27'h0, regOn, coreOn, link.mode}, {27'h0, 2'b01, MODE_ACTIVE});
        ahb(1'b1, OFS_CTRL, 32'h0);
        ahb(1'b1, OFS_INSTR, 32'h1);
        wait_mode(MODE_SLEEP);
        check({21'h0, outs}, 32'h778);
        irq <= 1'b1;
        wait_mode(MODE_ACTIVE);
        ahb(1'b1, OFS_INSTR, 32'h2);
        repeat (5) @(posedge clk);
        ahb(1'b0, OFS_STATUS, 32'h0);
        check(rdat, 32'h28);
        irq <= 1'b0;
        ahb(1'b1, OFS_WAKEEN, 32'h80000);
        ahb(1'b1, OFS_INSTR, 32'h2);
        wait_mode(MODE_SLEEP);
        alarms[3] <= 1'b1;
        wait_mode(MODE_ACTIVE);
        alarms <= 4'h0;
        for (int f = 0; f < 3; f++) begin
            ahb(1'b1, OFS_WAKEEN, 32'h0);
            v = (32'(f) << 4) | ((f == 1) ? 32'h4 : 32'h0);
            ahb(1'b1, OFS_CTRL, v);
            if (f == 1) ahb(1'b1, OFS_INSTR, 32'h2);
            else ahb(1'b1, OFS_CTRL, v | 32'h200);
            wait_mode(MODE_WAIT);
            check({21'h0, outs}, 32'h700 | (32'(f) << 3));
            alarms[1] <= 1'b1;
            if (f == 0) wakePins[0] <= 1'b0;
            else alarms[f + 1] <= 1'b1;
            repeat (10) @(posedge clk);
            check({29'h0, link.mode}, {29'h0, MODE_WAIT});
            ahb(1'b1, OFS_WAKEEN, (f == 0) ? 32'h1 : (32'h1 << (f + 17)));
            wait_mode(MODE_ACTIVE);
            check(32'(n < 1000), 32'h1);
            check({29'h0, link.masterClockReady, clkSrc}, 32'h4);
            wakePins <= 16'hFFFF;
            alarms <= 4'h0;
        end
        for (int b = 0; b < 2; b++) begin
            ahb(1'b1, OFS_WAKEEN, b ? 32'h10000 : 32'h8);
            ahb(1'b1, OFS_DEBOUNCE, 32'h3);
            if (b == 0) ahb(1'b1, OFS_CTRL, 32'hA5000001);
            else ahb(1'b1, OFS_CTRL, 32'h2);
            if (b == 1) ahb(1'b1, OFS_INSTR, 32'h2);
            wait_mode(MODE_BACKUP);
            check({29'h0, regOn, coreOn, pinHold}, 32'h1);
            alarms[1] <= 1'b1;
            repeat (10) @(posedge clk);
            check({29'h0, link.mode}, {29'h0, MODE_BACKUP});
            if (b == 0) wakePins[3] <= 1'b0;
            else alarms[0] <= 1'b1;
            sawPull <= 1'b0;
            wait_mode(MODE_ACTIVE);
            repeat (2) @(posedge clk);
            check(32'(n >= REG_CYC), 32'h1);
            check({27'h0, sawPull, pinHold, regOn, coreOn, sramOn}, 32'h17);
            wakePins <= 16'hFFFF;
            alarms <= 4'h0;
        end
        end_sim();
    end
endmodule : low_power_mode_sequencer_tb
`default_nettype wire

/* File: sim/lp_assertions.sv */
// concurrent checks on the controller-sequencer link
`default_nettype none
module lp_assertions #(
    parameter int REG_START_CYCLES  = 20,
    parameter int FAST_START_CYCLES = 200
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       regOffReq,
    input wire logic [7:0] regKey,
    input wire logic       deepSleepSelect,
    input wire logic       lowpowerOnEvent,
    input wire logic       waitEntryBit,
    input wire logic       waitForInterruptInstr,
    input wire logic       waitForEventInstr,
    input wire logic       eventPend,
    input wire logic       intPend,
    input wire logic [2:0] mode,
    input wire logic       masterClockReady,
    input wire logic       coreRst
);
    import lp_pkg::*;
    localparam int FAST_HI = FAST_START_CYCLES + 2;
    localparam int REG_HI  = REG_START_CYCLES + 4;
    logic pre;
    logic wfeGo;
    assign pre   = mode == MODE_ACTIVE && !(regOffReq && regKey == REG_OFF_KEY) && !waitEntryBit;
    assign wfeGo = waitForEventInstr && !eventPend && !waitForInterruptInstr;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // --------
    // mode entry
    // --------
    a_bad_key: assert property (
        pre && regOffReq && !waitForInterruptInstr && !waitForEventInstr |=> mode == MODE_ACTIVE)
        else $error("keyless regulator-off left active");
    a_key_backup: assert property (
        mode == MODE_ACTIVE && regOffReq && regKey == REG_OFF_KEY |=> mode == MODE_BACKUP)
        else $error("keyed regulator-off missed backup");
    a_wait_bit: assert property (
        mode == MODE_ACTIVE && !(regOffReq && regKey == REG_OFF_KEY) && waitEntryBit |=> mode == MODE_WAIT)
        else $error("wait entry bit missed wait");
    a_wfe_blocked: assert property (
        pre && waitForEventInstr && eventPend && !waitForInterruptInstr |=> mode == MODE_ACTIVE)
        else $error("pending event did not block entry");
    a_wfe_deep: assert property (
        pre && wfeGo && deepSleepSelect |=> mode == MODE_BACKUP)
        else $error("deep wfe missed backup");
    a_wfe_wait: assert property (
        pre && wfeGo && !deepSleepSelect && lowpowerOnEvent |=> mode == MODE_WAIT)
        else $error("lowpower wfe missed wait");
    a_sleep_entry: assert property (
        pre && !deepSleepSelect && !lowpowerOnEvent && !intPend && (waitForInterruptInstr || wfeGo)
        |=> mode == MODE_SLEEP)
        else $error("instruction missed sleep");
    // --------
    // wake-up
    // --------
    a_sleep_wake: assert property (
        mode == MODE_SLEEP && intPend |=> mode == MODE_ACTIVE)
        else $error("interrupt did not end sleep");
    a_wake_time: assert property (
        mode == MODE_WAKING && $past(mode) == MODE_WAIT |-> ##[1:FAST_HI] mode == MODE_ACTIVE)
        else $error("wait wake-up too slow");
    a_fast_clock: assert property (
        mode == MODE_ACTIVE && $past(mode) == MODE_WAKING |-> masterClockReady)
        else $error("master clock not ready at wake");
    a_backup_exit: assert property (
        mode == MODE_WAKING && $past(mode) == MODE_BACKUP |-> !coreRst [*8] ##[1:REG_HI] coreRst)
        else $error("core reset timing wrong after backup");
endmodule : lp_assertions
`default_nettype wire
